// >>> design/xcvr_consts.svh
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH

// Register byte offsets on the plain register port
`define XCVR_CTRL_OFFSET 4'h0
`define XCVR_STATUS_OFFSET 4'h4

// Control register fields
`define XCVR_CTRL_JOIN_BIT 0
`define XCVR_CTRL_RESET 32'h00000000

// Status register fields: drive flags low nibble, follow flags next nibble
`define XCVR_STATUS_DRIVE_LSB 0
`define XCVR_STATUS_FOLLOW_LSB 4

// Reset levels of the synchronised control pins: {revLe, fwdLe, revOeN, fwdOe}
`define XCVR_CTL_SYNC_RESET 8'h0C

`endif

// >>> design/xcvr_pkg.sv
`default_nettype none

package xcvr_pkg;

   // Storage behaviour of one path
   typedef enum logic [0:0]
   {
      PATH_HOLD = 1'b0,
      PATH_FOLLOW = 1'b1
   } pathMode_t;

   // Control levels that steer one path
   typedef struct packed
   {
      logic drive;
      logic latchEnable;
   } pathCtl_t;

   // One request on the register port
   typedef struct packed
   {
      logic [3:0] addr;
      logic [31:0] wrData;
      logic write;
      logic read;
   } regReq_t;

endpackage

`default_nettype wire

// >>> design/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] levelOut
);

   logic [WIDTH-1:0] stage1Reg;
   logic [WIDTH-1:0] stage2Reg;
   logic [WIDTH-1:0] stage3Reg;
   logic [WIDTH-1:0] level_next;
   logic [WIDTH-1:0] disagree;

   // Level moves only when stages two and three agree; otherwise the last
   // good level is kept; floating pins are not held, as agreeing stages always pass through
   always_comb
   begin
      disagree = stage2Reg ^ stage3Reg;
      level_next = (stage2Reg & ~disagree) | (levelOut & disagree);
   end

   // Three-stage chain; stage one feeds stage two only
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stage1Reg <= RESET_VAL;
         stage2Reg <= RESET_VAL;
         stage3Reg <= RESET_VAL;
         levelOut <= RESET_VAL;
      end
      else
      begin
         stage1Reg <= pinIn;
         stage2Reg <= stage1Reg;
         stage3Reg <= stage2Reg;
         levelOut <= level_next;
      end
   end

endmodule

`default_nettype wire

// >>> design/capture_port.sv
`timescale 1ns/1ns
`default_nettype none

module capture_port
#(
   parameter int WIDTH = 36
)
(
   input wire logic capClk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] dataIn,
   output logic [WIDTH-1:0] slot0,
   output logic [WIDTH-1:0] slot1,
   output logic wrPtr
);

   logic [WIDTH-1:0] slot0_next;
   logic [WIDTH-1:0] slot1_next;
   logic wrPtr_next;

   // Ping-pong slots: a word stays put for two capture edges, long enough
   // for the system side to see the pointer flip and read it
   always_comb
   begin
      slot0_next = slot0;
      slot1_next = slot1;
      if (wrPtr)
         slot1_next = dataIn;
      else
         slot0_next = dataIn;
      wrPtr_next = ~wrPtr;
   end

   // Runs on the capture clock only; every rising edge takes a word
   always_ff @(posedge capClk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         slot0 <= '0;
         slot1 <= '0;
         wrPtr <= 1'b0;
      end
      else
      begin
         slot0 <= slot0_next;
         slot1 <= slot1_next;
         wrPtr <= wrPtr_next;
      end
   end

endmodule

`default_nettype wire

// >>> design/bus_transceiver.sv
// Overview of operation
// - Two 18-bit halves with own controls, or one 36-bit unit when joined.
// - Latch enable high: path is transparent, output follows input.
// - Latch enable low, clock steady: stored data and outputs hold.
// - Latch enable low: rising capture clock edge stores input levels.
// - Forward output enable high drives B; low leaves B undriven.
// - Reverse path mirrors forward, its output enable active low.
// - Clock held high after latch enable fell: output keeps prior level.
// - Clock held low with latch enable low: output keeps prior level.
// - Undriven data inputs are not held; a synchronised level pauses only while stages two and three disagree.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "xcvr_consts.svh"

module bus_transceiver
#(
   parameter int HALF_WIDTH = 18,
   parameter int ADDR_WIDTH = 4,
   parameter int DATA_WIDTH = 32
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [1:0] fwdCaptureClock,
   input wire logic [1:0] revCaptureClock,
   input wire logic [1:0] fwdOutputEnable,
   input wire logic [1:0] revOutputEnableN,
   input wire logic [1:0] fwdLatchEnable,
   input wire logic [1:0] revLatchEnable,
   input wire logic [2*HALF_WIDTH-1:0] aIn,
   output logic [2*HALF_WIDTH-1:0] aOut,
   output logic [2*HALF_WIDTH-1:0] aOe,
   input wire logic [2*HALF_WIDTH-1:0] bIn,
   output logic [2*HALF_WIDTH-1:0] bOut,
   output logic [2*HALF_WIDTH-1:0] bOe,
   input wire logic [ADDR_WIDTH-1:0] regAddr,
   input wire logic [DATA_WIDTH-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [DATA_WIDTH-1:0] regRdData
);

   // Four paths: two directions, two halves each
   localparam int BUS_WIDTH = 2 * HALF_WIDTH;
   localparam int NUM_PATHS = 4;

   // Synchronised pin levels
   logic [BUS_WIDTH-1:0] aLevel;
   logic [BUS_WIDTH-1:0] bLevel;
   logic [7:0] ctlLevel;
   logic [1:0] fwdOeLevel;
   logic [1:0] revOeNLevel;
   logic [1:0] fwdLeLevel;
   logic [1:0] revLeLevel;

   // Capture side, index = direction * 2 + half
   logic [BUS_WIDTH-1:0] capSlot0 [NUM_PATHS];
   logic [BUS_WIDTH-1:0] capSlot1 [NUM_PATHS];
   logic [NUM_PATHS-1:0] capPtr;
   logic [NUM_PATHS-1:0] ptrLevel;
   logic [NUM_PATHS-1:0] ptrSeenReg;
   logic [NUM_PATHS-1:0] ptrSeen_next;
   logic [NUM_PATHS-1:0] capEvent;
   logic [BUS_WIDTH-1:0] capWord [NUM_PATHS];

   // Path storage and status
   logic [HALF_WIDTH-1:0] storeReg [NUM_PATHS];
   logic [HALF_WIDTH-1:0] store_next [NUM_PATHS];
   xcvr_pkg::pathMode_t modeReg [NUM_PATHS];
   xcvr_pkg::pathMode_t mode_next [NUM_PATHS];
   logic [NUM_PATHS-1:0] driveReg;
   logic [NUM_PATHS-1:0] drive_next;
   logic [NUM_PATHS-1:0] followVec;

   // Register port
   xcvr_pkg::regReq_t regReq;
   logic [DATA_WIDTH-1:0] ctrlReg;
   logic [DATA_WIDTH-1:0] ctrl_next;
   logic [DATA_WIDTH-1:0] regRdData_next;
   logic joinHalves;

   pin_sync
   #(
      .WIDTH(BUS_WIDTH),
      .RESET_VAL('0)
   )
   aSync
   (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pinIn(aIn),
      .levelOut(aLevel)
   );

   pin_sync
   #(
      .WIDTH(BUS_WIDTH),
      .RESET_VAL('0)
   )
   bSync
   (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pinIn(bIn),
      .levelOut(bLevel)
   );

   // Reverse enable resets high so no side drives before the pins settle
   pin_sync
   #(
      .WIDTH(8),
      .RESET_VAL(`XCVR_CTL_SYNC_RESET)
   )
   ctlSync
   (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pinIn({revLatchEnable, fwdLatchEnable, revOutputEnableN, fwdOutputEnable}),
      .levelOut(ctlLevel)
   );

   // Unpack the settled control levels
   assign fwdOeLevel = ctlLevel[1:0];
   assign revOeNLevel = ctlLevel[3:2];
   assign fwdLeLevel = ctlLevel[5:4];
   assign revLeLevel = ctlLevel[7:6];

   // Capture pointers cross as single toggling bits
   pin_sync
   #(
      .WIDTH(NUM_PATHS),
      .RESET_VAL('0)
   )
   ptrSync
   (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pinIn(capPtr),
      .levelOut(ptrLevel)
   );

   // One capture port per direction and half, each on its own clock
   genvar gc;
   generate
      for (gc = 0; gc < NUM_PATHS; gc++)
      begin : gCapture
         logic capClkSel;
         logic [BUS_WIDTH-1:0] capIn;
         // Forward ports sample A on their own clock, reverse ports sample B
         assign capClkSel = (gc < 2) ? fwdCaptureClock[gc % 2] : revCaptureClock[gc % 2];
         assign capIn = (gc < 2) ? aIn : bIn;

         capture_port
         #(
            .WIDTH(BUS_WIDTH)
         )
         port
         (
            .capClk(capClkSel),
            .sys_rst(sys_rst),
            .dataIn(capIn),
            .slot0(capSlot0[gc]),
            .slot1(capSlot1[gc]),
            .wrPtr(capPtr[gc])
         );

         // Last written slot is the one the pointer just left
         // Slots cross unsynchronised; safe only while capture edges are spread out
         assign capWord[gc] = ptrLevel[gc] ? capSlot0[gc] : capSlot1[gc];
         assign capEvent[gc] = ptrLevel[gc] ^ ptrSeenReg[gc];
      end
   endgenerate

   // Edge detect on the settled pointer levels
   always_comb
   begin
      ptrSeen_next = ptrLevel;
   end

   // Zero after reset matches the pointer reset, so no false event follows
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         ptrSeenReg <= '0;
      else
         ptrSeenReg <= ptrSeen_next;
   end

   // Join bit steers the upper half onto the lower half's controls
   assign joinHalves = ctrlReg[`XCVR_CTRL_JOIN_BIT];

   // Storage per direction and half, each with its own registers
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PATHS; gp++)
      begin : gPath
         localparam int HALF = gp % 2;
         localparam int DIR = gp / 2;
         localparam int LSB = HALF * HALF_WIDTH;
         int ctlIdx;
         int ctlHalf;
         xcvr_pkg::pathCtl_t ctl;
         logic [HALF_WIDTH-1:0] liveIn;

         // joined mode hands half two to half one's controls
         always_comb
         begin
            // Joined paths also take the lower half's capture port
            ctlHalf = joinHalves ? 0 : HALF;
            ctlIdx = DIR * 2 + ctlHalf;
            if (DIR == 0)
            begin
               ctl.drive = fwdOeLevel[ctlHalf];
               ctl.latchEnable = fwdLeLevel[ctlHalf];
               liveIn = aLevel[LSB +: HALF_WIDTH];
            end
            else
            begin
               ctl.drive = ~revOeNLevel[ctlHalf];
               ctl.latchEnable = revLeLevel[ctlHalf];
               liveIn = bLevel[LSB +: HALF_WIDTH];
            end
         end

         always_comb
         begin
            store_next[gp] = storeReg[gp];
            mode_next[gp] = xcvr_pkg::PATH_HOLD;
            drive_next[gp] = ctl.drive;
            // Transparent mode wins over a pending capture event
            if (ctl.latchEnable)
            begin
               mode_next[gp] = xcvr_pkg::PATH_FOLLOW;
               store_next[gp] = liveIn;
            end
            else if (capEvent[ctlIdx])
            begin
               store_next[gp] = capWord[ctlIdx][LSB +: HALF_WIDTH];
            end
            else
            begin
               store_next[gp] = storeReg[gp];
            end
         end

         // Path registers; reset leaves every side undriven
         always_ff @(posedge clk_sys or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               storeReg[gp] <= '0;
               modeReg[gp] <= xcvr_pkg::PATH_HOLD;
               driveReg[gp] <= 1'b0;
            end
            else
            begin
               storeReg[gp] <= store_next[gp];
               modeReg[gp] <= mode_next[gp];
               driveReg[gp] <= drive_next[gp];
            end
         end

         // Transparent flag for the status word
         assign followVec[gp] = (modeReg[gp] == xcvr_pkg::PATH_FOLLOW);

         // forward drives B only when enabled
         if (DIR == 0)
         begin : gToB
            assign bOut[LSB +: HALF_WIDTH] = storeReg[gp];
            assign bOe[LSB +: HALF_WIDTH] = {HALF_WIDTH{driveReg[gp]}};
         end
         else
         begin : gToA
            assign aOut[LSB +: HALF_WIDTH] = storeReg[gp];
            assign aOe[LSB +: HALF_WIDTH] = {HALF_WIDTH{driveReg[gp]}};
         end
      end
   endgenerate

   // Bundle the register request
   assign regReq.addr = regAddr;
   assign regReq.wrData = regWrData;
   assign regReq.write = regWrite;
   assign regReq.read = regRead;

   // Register decode; unmapped reads return zero, writes there are dropped
   always_comb
   begin
      ctrl_next = ctrlReg;
      regRdData_next = '0;
      if (regReq.write && regReq.addr == `XCVR_CTRL_OFFSET)
      begin
         ctrl_next = '0;
         ctrl_next[`XCVR_CTRL_JOIN_BIT] = regReq.wrData[`XCVR_CTRL_JOIN_BIT];
      end
      // Read data built here, registered below
      if (regReq.read)
      begin
         if (regReq.addr == `XCVR_CTRL_OFFSET)
            regRdData_next = ctrlReg;
         else if (regReq.addr == `XCVR_STATUS_OFFSET)
         begin
            regRdData_next[`XCVR_STATUS_DRIVE_LSB +: NUM_PATHS] = driveReg;
            regRdData_next[`XCVR_STATUS_FOLLOW_LSB +: NUM_PATHS] = followVec;
         end
      end
   end

   // Read data stands for exactly one cycle after the strobe
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrlReg <= `XCVR_CTRL_RESET;
         regRdData <= '0;
      end
      else
      begin
         ctrlReg <= ctrl_next;
         regRdData <= regRdData_next;
      end
   end

endmodule

`default_nettype wire

// >>> sim/xcvr_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module xcvr_assertions
#(
   parameter int HALF_WIDTH = 18
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [1:0] fwdCaptureClock,
   input wire logic [1:0] revCaptureClock,
   input wire logic [1:0] fwdOutputEnable,
   input wire logic [1:0] revOutputEnableN,
   input wire logic [1:0] fwdLatchEnable,
   input wire logic [1:0] revLatchEnable,
   input wire logic [2*HALF_WIDTH-1:0] aIn,
   input wire logic [2*HALF_WIDTH-1:0] aOut,
   input wire logic [2*HALF_WIDTH-1:0] aOe,
   input wire logic [2*HALF_WIDTH-1:0] bIn,
   input wire logic [2*HALF_WIDTH-1:0] bOut,
   input wire logic [2*HALF_WIDTH-1:0] bOe
);
   localparam int H = HALF_WIDTH;
   // Windows leave room for the four-flop pin synchronisers
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   chk_reset_idle: assert property ($fell(sys_rst) |-> aOe == '0 && bOe == '0)
      else $error("drivers active after reset");
   chk_fwd_on: assert property (fwdOutputEnable[0] [*6] |-> &bOe[H-1:0])
      else $error("B side not driven");
   chk_fwd_off: assert property (!fwdOutputEnable[0] [*6] |-> bOe[H-1:0] == '0)
      else $error("B side driven while disabled");
   chk_rev_on: assert property (!revOutputEnableN[0] [*6] |-> &aOe[H-1:0])
      else $error("A side not driven");
   chk_rev_off: assert property (revOutputEnableN[0] [*6] |-> aOe[H-1:0] == '0)
      else $error("A side driven while disabled");
   chk_fwd_follow: assert property ((fwdLatchEnable[0] && $stable(aIn[H-1:0])) [*7] |-> bOut[H-1:0] == aIn[H-1:0])
      else $error("B output not following A");
   chk_fwd_hold: assert property ((!fwdLatchEnable[0] && $stable(fwdCaptureClock[0])) [*8] |=> $stable(bOut[H-1:0]))
      else $error("B output moved while latched");
   chk_rev_follow: assert property ((revLatchEnable[0] && $stable(bIn[H-1:0])) [*7] |-> aOut[H-1:0] == bIn[H-1:0])
      else $error("A output not following B");
   chk_rev_hold: assert property ((!revLatchEnable[0] && $stable(revCaptureClock[0])) [*8] |=> $stable(aOut[H-1:0]))
      else $error("A output moved while latched");
   chk_upper_hold: assert property ((fwdLatchEnable == 2'h0 && $stable(fwdCaptureClock)) [*8] |=> $stable(bOut[2*H-1:H]))
      else $error("upper half moved while latched");
   // Main scenarios reached
   cover property (fwdLatchEnable[0] ##1 !fwdLatchEnable[0]);
   cover property ($rose(fwdCaptureClock[0]) && !fwdLatchEnable[0]);
   cover property (!revOutputEnableN[0] && revLatchEnable[0]);
endmodule
bind bus_transceiver xcvr_assertions #(.HALF_WIDTH(HALF_WIDTH)) i_xcvr_assertions (.clk_sys, .sys_rst,
   .fwdCaptureClock, .revCaptureClock, .fwdOutputEnable, .revOutputEnableN, .fwdLatchEnable, .revLatchEnable,
   .aIn, .aOut, .aOe, .bIn, .bOut, .bOe);
`default_nettype wire

// >>> sim/far_bus.sv
`timescale 1ns/1ns
`default_nettype none
module far_bus
(
   input wire logic [35:0] aOut,
   input wire logic [35:0] aOe,
   input wire logic [35:0] bOut,
   input wire logic [35:0] bOe,
   input wire logic [35:0] aSrc,
   input wire logic [35:0] bSrc,
   output logic [35:0] aIn,
   output logic [35:0] bIn,
   output logic [1:0] fwdCaptureClock,
   output logic [1:0] revCaptureClock
);
   logic linkClk;
   logic [3:0] clkLvl = 4'h0;
   // Link clock, phase unrelated to the system clock
   initial
   begin
      linkClk = 1'b0;
      #13;
      forever #80 linkClk = ~linkClk;
   end
   assign aIn = (aOe & aOut) | (~aOe & aSrc);
   assign bIn = (bOe & bOut) | (~bOe & bSrc);
   assign fwdCaptureClock = clkLvl[1:0];
   assign revCaptureClock = clkLvl[3:2];
   // Capture pins move only on link edges, so they stand still between frames
   task automatic linkEdge(input int idx, input logic lvl);
      @(negedge linkClk);
      clkLvl[idx] = lvl;
   endtask
endmodule
`default_nettype wire

// >>> sim/universal_bus_transceiver_36bit_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "xcvr_consts.svh"
module universal_bus_transceiver_36bit_test;
   localparam logic [35:0] A1 = 36'h9A5C3F00F;
   localparam logic [35:0] A2 = 36'h365A0CFF0;
   localparam logic [35:0] A3 = 36'hC3F0A5A5A;
   localparam logic [35:0] B1 = 36'h5A5A3C3C3;
   localparam logic [35:0] B2 = 36'hA0F50FA0F;
   localparam logic [35:0] ONES = 36'hFFFFFFFFF;
   logic clk_sys, sys_rst, regWrite, regRead;
   logic [1:0] fwdCaptureClock, revCaptureClock, fwdOutputEnable, revOutputEnableN, fwdLatchEnable, revLatchEnable;
   logic [35:0] aIn, aOut, aOe, bIn, bOut, bOe, aSrc, bSrc;
   logic [3:0] regAddr;
   logic [31:0] regWrData, regRdData;
   int errors = 0;
   int comparisons = 0;
   bus_transceiver i_bus_transceiver (.clk_sys, .sys_rst, .fwdCaptureClock, .revCaptureClock, .fwdOutputEnable,
      .revOutputEnableN, .fwdLatchEnable, .revLatchEnable, .aIn, .aOut, .aOe, .bIn, .bOut, .bOe, .regAddr,
      .regWrData, .regWrite, .regRead, .regRdData);
   far_bus i_far_bus (.aOut, .aOe, .bOut, .bOe, .aSrc, .bSrc, .aIn, .bIn, .fwdCaptureClock, .revCaptureClock);
   // System clock
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Register port, one-cycle strobes
   task automatic regWr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   task automatic regRd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      // Data stands for one cycle; taken at the edge that closes it
      @(posedge clk_sys);
      cmp({4'h0, regRdData}, {4'h0, exp});
   endtask
   task automatic complete_run;
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic checkReset;
      cmp(aOe, 36'h0);
      cmp(bOe, 36'h0);
      regRd(`XCVR_CTRL_OFFSET, 32'h00000000);
      regRd(4'h8, 32'h00000000);
   endtask
   task automatic checkFollow;
      fwdLatchEnable <= 2'h3;
      fwdOutputEnable <= 2'h1;
      aSrc <= A1;
      waitc(8);
      cmp(bOut, A1);
      cmp(bOe, {18'h00000, 18'h3FFFF});
      regRd(`XCVR_STATUS_OFFSET, 32'h00000031);
   endtask
   task automatic checkHoldCapture;
      i_far_bus.linkEdge(0, 1'b1);
      waitc(8);
      fwdLatchEnable <= 2'h0;
      waitc(6);
      aSrc <= A2;
      waitc(10);
      cmp(bOut, A1);
      i_far_bus.linkEdge(0, 1'b0);
      waitc(10);
      cmp(bOut, A1);
      i_far_bus.linkEdge(0, 1'b1);
      waitc(12);
      cmp(bOut, {A1[35:18], A2[17:0]});
      i_far_bus.linkEdge(0, 1'b0);
   endtask
   task automatic checkJoined;
      regWr(`XCVR_CTRL_OFFSET, 32'h00000001);
      regRd(`XCVR_CTRL_OFFSET, 32'h00000001);
      fwdLatchEnable <= 2'h2;
      aSrc <= A3;
      waitc(8);
      cmp(bOe, ONES);
      i_far_bus.linkEdge(0, 1'b1);
      waitc(12);
      cmp(bOut, A3);
      i_far_bus.linkEdge(0, 1'b0);
      regWr(`XCVR_CTRL_OFFSET, 32'h00000000);
      fwdLatchEnable <= 2'h0;
   endtask
   task automatic checkReverse;
      fwdOutputEnable <= 2'h0;
      waitc(6);
      cmp(bOe, 36'h0);
      revLatchEnable <= 2'h3;
      revOutputEnableN <= 2'h0;
      bSrc <= B1;
      waitc(8);
      cmp(aOut, B1);
      cmp(aOe, ONES);
      cmp(bOut, A3);
      revOutputEnableN <= 2'h3;
      revLatchEnable <= 2'h0;
      waitc(6);
      cmp(aOe, 36'h0);
      bSrc <= B2;
      i_far_bus.linkEdge(2, 1'b1);
      waitc(12);
      cmp(aOut, {B1[35:18], B2[17:0]});
      i_far_bus.linkEdge(2, 1'b0);
   endtask
   // Main sequence; both enables start inactive as during power ramps
   initial
   begin
      sys_rst = 1'b1;
      fwdOutputEnable = 2'h0;
      revOutputEnableN = 2'h3;
      fwdLatchEnable = 2'h0;
      revLatchEnable = 2'h0;
      aSrc = 36'h0;
      bSrc = 36'h0;
      regAddr = 4'h0;
      regWrData = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      waitc(2);
      checkReset();
      checkFollow();
      checkHoldCapture();
      checkJoined();
      checkReverse();
      complete_run();
   end
   // Watchdog, far beyond the under two hundred cycles the run needs
   initial
   begin
      #200000;
      errors++;
      complete_run();
   end
endmodule
`default_nettype wire
